//--- clkgen_pkg.sv
//
// Notes on behaviour
// RQ1: source status reads 0 for slow 32 kHz IRC, 1 for fast 4 MHz.
// RQ2: source status follows select only after sync, only while IRC enabled.
// RQ3: writing 1 to bit 7 starts trimming the selected reference.
// RQ4: trim enable clears itself once every trim bit is decided.
// RQ5: writes to control 1, 3, 4, status/control or stop entry abort.
// RQ6: bit 6 picks the reference: 0 slow 32 kHz, 1 fast 4 MHz.
// RQ7: fail flag, bit 5, sets when an abort hits a running trim.
// RQ8: software writing the fail flag clears it.
// RQ9: preserve bit 4 low: filter state resets on clock mode change.
// RQ10: preserve high: filter kept across mode changes with valid output.
// RQ11: software keeps FLL reference unchanged when relying on preserve.
// RQ12: status/control is 8 bits at 8h, reset 02h, divider and loss bits.
package clkgen_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL1      = 8'h00;
    localparam logic [7:0] ADDR_CTRL3      = 8'h04;
    localparam logic [7:0] ADDR_SC         = 8'h08;
    localparam logic [7:0] ADDR_CTRL4      = 8'h0c;
    localparam logic [7:0] ADDR_STATUS     = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h1c;
    localparam logic [7:0] ADDR_FILTER     = 8'h20;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int SC_TRIM_ENABLE = 7;
    localparam int SC_TRIM_SELECT = 6;
    localparam int SC_TRIM_FAIL   = 5;
    localparam int SC_PRESERVE    = 4;
    localparam int SC_DIV_MSB     = 3;
    localparam int SC_DIV_LSB     = 1;
    localparam int SC_LOSS        = 0;
    localparam logic [7:0] SC_RESET = 8'h02;
    localparam int C1_REF_SELECT  = 0;
    localparam int C1_IRC_ENABLE  = 1;
    localparam int C1_MODE_MSB    = 7;
    localparam int C1_MODE_LSB    = 6;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] TRIM_RESET  = 8'h80;
    localparam logic [1:0] MODE_USES_IRC = 2'h1;
    localparam int ST_REF_SOURCE  = 0;
    localparam int ST_TRIM_BUSY   = 1;
    localparam int ST_FLL_VALID   = 2;
    // ------------------------------------------------------------
    // interrupt bits
    // ------------------------------------------------------------
    localparam int IRQ_TRIM_DONE  = 0;
    localparam int IRQ_TRIM_FAIL  = 1;
    localparam int IRQ_SRC_CHANGE = 2;
    localparam int IRQ_WIDTH      = 3;
    // ------------------------------------------------------------
    // timing and filter
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int TRIM_SETTLE_NS = 1000;
    localparam int TRIM_SETTLE_CYCLES =
        (TRIM_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_WIDTH   = 10;
    localparam int TRIM_WIDTH     = 8;
    typedef enum logic [1:0] {
        TRIM_IDLE   = 2'b00,
        TRIM_SETTLE = 2'b01,
        TRIM_DECIDE = 2'b10
    } trim_state_t;
endpackage : clkgen_pkg

//--- clkgen_status_control.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
// status and control of the clock generator: trim machine, filter
// preserve, reference source status, apb registers and interrupt
module clkgen_status_control
    import clkgen_pkg::*;
#(
    parameter int FW = FILTER_WIDTH,
    parameter int TW = TRIM_WIDTH
) (
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // apb slave
    input  wire logic [7:0]    paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // power controller, same clock
    input  wire logic          stop_mode,
    // analog pins, asynchronous
    input  wire logic          irc_too_fast,
    input  wire logic          osc_loss,
    input  wire logic          fll_up,
    input  wire logic          fll_down,
    input  wire logic          fll_output_valid,
    // clock generator controls
    output logic [TW-1:0]      slow_trim,
    output logic [TW-1:0]      fast_trim,
    output logic [2:0]         fast_irc_divider,
    output logic               internal_ref_select,
    output logic               irc_enable,
    output logic [1:0]         clock_mode,
    output logic [FW-1:0]      fll_filter_value,
    // interrupt
    output logic               irq
);
    if (FW < 2 || FW > 16 || TW != 8) begin : g_bad
        $error("clkgen_status_control: unsupported FW or TW");
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]           ctrl1;
    logic [TW-1:0]        ctrl3;
    logic [TW-1:0]        ctrl4;
    logic                 trim_enable;
    logic                 trim_select;
    logic                 trim_fail_flag;
    logic                 filter_preserve;
    logic [2:0]           fast_irc_div;
    logic                 osc_loss_of_clock_status;
    logic                 internal_ref_source_status;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_enable;
    logic [FW-1:0]        filter;
    logic                 stop_d;
    logic [7:0]           rd_byte_q;

    // ------------------------------------------------------------
    // synchronised pins
    // ------------------------------------------------------------
    logic [4:0] pins_s;
    logic       ref_select_s;

    sync2 #(.WIDTH(5)) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({irc_too_fast, osc_loss, fll_up, fll_down,
                   fll_output_valid}),
        .q       (pins_s)
    );

    wire too_fast_s  = pins_s[4];
    wire osc_loss_s  = pins_s[3];
    wire fll_up_s    = pins_s[2];
    wire fll_down_s  = pins_s[1];
    wire fll_valid_s = pins_s[0];

    // select crosses into the oscillator's domain and back
    sync2 #(.WIDTH(1)) u_ref_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (ctrl1[C1_REF_SELECT]),
        .q       (ref_select_s)
    );

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire setup     = psel & ~penable;
    wire access    = psel & penable;
    wire hit_c1    = (paddr == ADDR_CTRL1);
    wire hit_c3    = (paddr == ADDR_CTRL3);
    wire hit_sc    = (paddr == ADDR_SC);
    wire hit_c4    = (paddr == ADDR_CTRL4);
    wire hit_st    = (paddr == ADDR_STATUS);
    wire hit_is    = (paddr == ADDR_IRQ_STATUS);
    wire hit_ie    = (paddr == ADDR_IRQ_ENABLE);
    wire hit_ic    = (paddr == ADDR_IRQ_CLEAR);
    wire hit_flt   = (paddr == ADDR_FILTER);
    wire mapped    = hit_c1 | hit_c3 | hit_sc | hit_c4 | hit_st
                   | hit_is | hit_ie | hit_ic | hit_flt;
    wire wr        = access & pwrite & mapped;
    wire wr_c1     = wr & hit_c1;
    wire wr_c3     = wr & hit_c3;
    wire wr_sc     = wr & hit_sc;
    wire wr_c4     = wr & hit_c4;
    wire [7:0] wb  = pwdata[7:0];

    // no wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // ------------------------------------------------------------
    // trim machine control
    // ------------------------------------------------------------
    logic [TW-1:0] trim_code;
    logic          trim_busy;
    logic          trim_done_raw;

    wire stop_entry = stop_mode & ~stop_d;
    wire abort_wr   = wr_c1 | wr_c3 | wr_c4 | wr_sc;
    // any of these kills a running trim    [RQ5]
    wire trim_abort = trim_enable & (abort_wr | stop_entry);
    // a start is refused while stopped or while already running
    wire trim_start = wr_sc & wb[SC_TRIM_ENABLE] & ~trim_enable
                    & ~stop_mode;                             // [RQ3]
    wire trim_done  = trim_done_raw & ~trim_abort;

    trim_sar #(.WIDTH(TW), .SETTLE(TRIM_SETTLE_CYCLES)) u_trim (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (trim_start),
        .abort    (trim_abort),
        .too_fast (too_fast_s),
        .code     (trim_code),
        .busy     (trim_busy),
        .done     (trim_done_raw)
    );

    // enable falls on completion or abort, rises only on a start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_enable <= 1'b0;
            stop_d      <= 1'b0;
        end else begin
            stop_d <= stop_mode;
            if (trim_abort || trim_done) begin
                trim_enable <= 1'b0;                          // [RQ4] [RQ5]
            end else if (trim_start) begin
                trim_enable <= 1'b1;                          // [RQ3]
            end
        end
    end

    // fail flag: the set wins over a clearing write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_fail_flag <= 1'b0;
        end else if (trim_abort) begin
            trim_fail_flag <= 1'b1;                           // [RQ7]
        end else if (wr_sc && wb[SC_TRIM_FAIL]) begin
            trim_fail_flag <= 1'b0;                           // [RQ8]
        end
    end

    // ------------------------------------------------------------
    // status/control plain fields and trim values
    // ------------------------------------------------------------
    // trim result lands in the register of the selected reference
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_select     <= SC_RESET[SC_TRIM_SELECT];
            filter_preserve <= SC_RESET[SC_PRESERVE];
            fast_irc_div    <= SC_RESET[SC_DIV_MSB:SC_DIV_LSB]; // [RQ12]
            ctrl1           <= CTRL1_RESET;
            ctrl3           <= TRIM_RESET;
            ctrl4           <= TRIM_RESET;
        end else begin
            if (wr_sc) begin
                trim_select     <= wb[SC_TRIM_SELECT];        // [RQ6]
                filter_preserve <= wb[SC_PRESERVE];
                fast_irc_div    <= wb[SC_DIV_MSB:SC_DIV_LSB];
            end
            if (wr_c1) begin
                ctrl1 <= wb;
            end
            if (wr_c3) begin
                ctrl3 <= wb;
            end else if (trim_done && !trim_select) begin
                ctrl3 <= trim_code;                           // [RQ6]
            end
            if (wr_c4) begin
                ctrl4 <= wb;
            end else if (trim_done && trim_select) begin
                ctrl4 <= trim_code;                           // [RQ6]
            end
        end
    end

    // oscillator loss is sticky; write 1 clears, a new loss wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_loss_of_clock_status <= SC_RESET[SC_LOSS];
        end else if (osc_loss_s) begin
            osc_loss_of_clock_status <= 1'b1;
        end else if (wr_sc && wb[SC_LOSS]) begin
            osc_loss_of_clock_status <= 1'b0;                 // [RQ12]
        end
    end

    // ------------------------------------------------------------
    // internal reference source status
    // ------------------------------------------------------------
    wire [1:0] mode_now  = ctrl1[C1_MODE_MSB:C1_MODE_LSB];
    wire       irc_on    = ctrl1[C1_IRC_ENABLE]
                         | (mode_now == MODE_USES_IRC);
    // status holds its old value while the reference is off
    wire       src_load  = irc_on & (ref_select_s
                         != internal_ref_source_status);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_ref_source_status <= 1'b0;
        end else if (src_load) begin
            internal_ref_source_status <= ref_select_s;       // [RQ1] [RQ2]
        end
    end

    // ------------------------------------------------------------
    // fll filter
    // ------------------------------------------------------------
    localparam logic [FW-1:0] FILT_RESET = FW'(1) << (FW - 1);
    localparam logic [FW-1:0] FILT_MAX   = '1;

    wire mode_change = wr_c1 & (wb[C1_MODE_MSB:C1_MODE_LSB] != mode_now);
    // preserve only helps when the dco output stays valid;
    // the reference itself must not move meanwhile
    wire keep_filter = filter_preserve & fll_valid_s;        // [RQ10] [RQ11]
    wire filt_inc    = fll_up_s & ~fll_down_s & (filter != FILT_MAX);
    wire filt_dec    = fll_down_s & ~fll_up_s & (filter != '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter <= FILT_RESET;
        end else if (mode_change && !keep_filter) begin
            filter <= FILT_RESET;                             // [RQ9]
        end else if (filt_inc) begin
            filter <= filter + FW'(1);
        end else if (filt_dec) begin
            filter <= filter - FW'(1);
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    wire [IRQ_WIDTH-1:0] irq_set = {src_load, trim_abort, trim_done};
    wire [IRQ_WIDTH-1:0] irq_clr = (wr & hit_ic) ? wb[IRQ_WIDTH-1:0]
                                                 : '0;

    // sticky status, new events beat a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
            irq_enable <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            if (wr && hit_ie) begin
                irq_enable <= wb[IRQ_WIDTH-1:0];
            end
        end
    end

    assign irq = |(irq_status & irq_enable);

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire [7:0] sc_read = {trim_enable, trim_select, trim_fail_flag,
                          filter_preserve, fast_irc_div,
                          osc_loss_of_clock_status};
    wire [7:0] st_read = {5'h00, fll_valid_s, trim_busy,
                          internal_ref_source_status};
    wire [7:0] flt_byte = filter[FW-1 -: 8];
    // write-only clear register reads zero
    wire [7:0] rd_byte =
        hit_c1  ? ctrl1 :
        hit_c3  ? ctrl3 :
        hit_sc  ? sc_read :
        hit_c4  ? ctrl4 :
        hit_st  ? st_read :
        hit_is  ? {5'h00, irq_status} :
        hit_ie  ? {5'h00, irq_enable} :
        hit_flt ? flt_byte : 8'h00;

    // data captured in the setup cycle, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_byte_q <= 8'h00;
        end else if (setup && !pwrite) begin
            rd_byte_q <= rd_byte;
        end
    end

    assign prdata = {24'h000000, rd_byte_q};

    // ------------------------------------------------------------
    // outputs to the clock generator
    // ------------------------------------------------------------
    // during a trim the analog side sees the trial code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_trim <= TRIM_RESET;
            fast_trim <= TRIM_RESET;
        end else begin
            slow_trim <= (trim_busy && !trim_select) ? trim_code : ctrl3;
            fast_trim <= (trim_busy && trim_select)  ? trim_code : ctrl4;
        end
    end

    assign fast_irc_divider    = fast_irc_div;
    assign internal_ref_select = ctrl1[C1_REF_SELECT];
    assign irc_enable          = irc_on;
    assign clock_mode          = mode_now;
    assign fll_filter_value    = filter;
endmodule : clkgen_status_control

//--- irc_auto_trim_status_control_bench.sv
`timescale 1ns/1ps
module irc_auto_trim_status_control_bench
    import clkgen_pkg::*;
;
    typedef struct {
        logic [7:0]  a;
        logic [7:0]  d;
        logic [31:0] e;
        logic        se;
    } row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, slow_trim, fast_trim;
    logic [31:0] pwdata, prdata, rd;
    logic        stop_mode, irc_too_fast, osc_loss, fll_up, fll_down;
    logic        fll_output_valid, internal_ref_select, irc_enable, irq;
    logic        err;
    logic [2:0]  fast_irc_divider;
    logic [1:0]  clock_mode;
    logic [9:0]  fll_filter_value;
    int          fails, num_checks;
    row_t        rows [5] = '{'{8'h08, 8'h0e, 32'h0e, 1'b0},
        '{8'h08, 8'h50, 32'h50, 1'b0}, '{8'h18, 8'h07, 32'h07, 1'b0},
        '{8'h24, 8'h5a, 32'h00, 1'b1}, '{8'h08, 8'h02, 32'h02, 1'b0}};
    logic [7:0]  ab_a [4] = '{ADDR_CTRL1, ADDR_CTRL3, ADDR_CTRL4, ADDR_SC};
    logic [7:0]  ab_d [4] = '{8'h02, 8'h80, 8'h80, 8'h80};

    clkgen_status_control dut_u (.pclk, .presetn, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .stop_mode,
        .irc_too_fast, .osc_loss, .fll_up, .fll_down, .fll_output_valid,
        .slow_trim, .fast_trim, .fast_irc_divider, .internal_ref_select,
        .irc_enable, .clock_mode, .fll_filter_value, .irq);

    // ----------------
    // helpers
    // ----------------
    task automatic complete_run;
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    task automatic chk(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // one apb transfer, held until pready
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    task automatic rdchk(input string n, input logic [7:0] a,
                         input logic [31:0] e);
        bus(a, 1'b0, 8'h00);
        chk(n, rd, e);
    endtask : rdchk

    // reads never abort a trim
    task automatic trim_wait;
        do bus(ADDR_SC, 1'b0, 8'h00); while (rd[SC_TRIM_ENABLE] !== 1'b0);
    endtask : trim_wait

    // 40 counts up, then let the synchroniser drain
    task automatic pump;
        fll_up <= 1'b1;
        repeat (40) @(posedge pclk);
        fll_up <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask : pump

    // ----------------
    // clock, watchdog and main sequence
    // ----------------
    always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        complete_run();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, stop_mode} = '0;
        {irc_too_fast, osc_loss, fll_up, fll_down} = '0;
        {paddr, pwdata, fails, num_checks} = '0;
        fll_output_valid = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            bus(rows[i].a, 1'b1, rows[i].d);
            chk("slverr", err, rows[i].se);
            rdchk("row", rows[i].a, rows[i].e);
        end
        bus(ADDR_CTRL1, 1'b1, 8'h01);
        repeat (5) @(posedge pclk);
        rdchk("src off", ADDR_STATUS, 32'h4);
        bus(ADDR_CTRL1, 1'b1, 8'h03);
        repeat (5) @(posedge pclk);
        rdchk("src fast", ADDR_STATUS, 32'h5);
        chk("irq src", irq, 1'b1);
        bus(ADDR_CTRL1, 1'b1, 8'h02);
        repeat (5) @(posedge pclk);
        rdchk("src slow", ADDR_STATUS, 32'h4);
        bus(ADDR_IRQ_CLEAR, 1'b1, 8'h07);
        @(posedge pclk);
        chk("irq clr", irq, 1'b0);
        bus(ADDR_SC, 1'b1, 8'h80);
        repeat (3) @(posedge pclk);
        rdchk("run", ADDR_SC, 32'h80);
        trim_wait();
        chk("done", rd, 32'h00);
        chk("slow", slow_trim, 8'hff);
        chk("fast", fast_trim, 8'h80);
        chk("irq done", irq, 1'b1);
        bus(ADDR_IRQ_ENABLE, 1'b1, 8'h00);
        @(posedge pclk);
        chk("irq mask", irq, 1'b0);
        bus(ADDR_IRQ_CLEAR, 1'b1, 8'h07);
        bus(ADDR_IRQ_ENABLE, 1'b1, 8'h07);
        irc_too_fast <= 1'b1;
        bus(ADDR_SC, 1'b1, 8'hc0);
        trim_wait();
        chk("fast4m", fast_trim, 8'h00);
        chk("slow32k", slow_trim, 8'hff);
        for (int i = 0; i < 5; i++) begin
            bus(ADDR_SC, 1'b1, 8'h80);
            repeat (3) @(posedge pclk);
            if (i < 4) begin
                bus(ab_a[i], 1'b1, ab_d[i]);
            end else begin
                stop_mode <= 1'b1;
                repeat (10) @(posedge pclk);
                stop_mode <= 1'b0;
            end
            rdchk("abort", ADDR_SC, 32'h20);
            bus(ADDR_SC, 1'b1, 8'h20);
            rdchk("fail clr", ADDR_SC, 32'h00);
        end
        pump();
        rdchk("filt up", ADDR_FILTER, 32'h8a);
        bus(ADDR_CTRL1, 1'b1, 8'h42);
        rdchk("filt rst", ADDR_FILTER, 32'h80);
        pump();
        bus(ADDR_SC, 1'b1, 8'h10);
        bus(ADDR_CTRL1, 1'b1, 8'h02);
        rdchk("filt keep", ADDR_FILTER, 32'h8a);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("div rst", fast_irc_divider, 3'h1);
        presetn <= 1'b1;
        rdchk("sc rst", ADDR_SC, 32'h02);
        complete_run();
    end
endmodule : irc_auto_trim_status_control_bench

//--- irc_trim_props.sv
`timescale 1ns/1ps
module irc_trim_props
    import clkgen_pkg::*;
#(
    parameter int FW = FILTER_WIDTH,
    parameter int TW = TRIM_WIDTH
) (
    // clock, reset and bus
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic [7:0]    paddr,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [31:0]   pwdata,
    // device side
    input wire logic          stop_mode,
    input wire logic          fll_up,
    input wire logic          fll_down,
    input wire logic [TW-1:0] slow_trim,
    input wire logic [TW-1:0] fast_trim,
    input wire logic [2:0]    fast_irc_divider,
    input wire logic          internal_ref_select,
    input wire logic          irc_enable,
    input wire logic [1:0]    clock_mode,
    input wire logic [FW-1:0] fll_filter_value,
    input wire logic          irq
);
    // ----------------
    // bus write decode
    // ----------------
    logic wr;
    logic hold;
    assign wr = psel && penable && pwrite;
    // a ctrl1 write may reset the filter
    assign hold = fll_up == fll_down && !(wr && paddr == ADDR_CTRL1);
    // ----------------
    // properties
    // ----------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_reset_vals: assert property ($rose(presetn) |->
        fast_irc_divider == 3'h1 && slow_trim == 8'h80
        && fast_trim == 8'h80) else $error("reset values wrong");
    chk_irq_reset: assert property ($rose(presetn) |-> !irq)
        else $error("irq high after reset");
    chk_div_write: assert property (wr && paddr == ADDR_SC
        && !pwdata[SC_TRIM_ENABLE] |=> fast_irc_divider ==
        $past(pwdata[SC_DIV_MSB:SC_DIV_LSB]))
        else $error("divider not written");
    chk_one_trim: assert property ($changed(slow_trim) |->
        $stable(fast_trim)) else $error("both trim codes moved");
    chk_ref_select: assert property (wr && paddr == ADDR_CTRL1 |=>
        internal_ref_select == $past(pwdata[C1_REF_SELECT])
        && clock_mode == $past(pwdata[C1_MODE_MSB:C1_MODE_LSB]))
        else $error("ctrl1 not taken");
    chk_irc_mode: assert property (clock_mode == MODE_USES_IRC
        |-> irc_enable) else $error("irc off in irc mode");
    chk_stop_hold: assert property ($rose(stop_mode) |-> ##3
        ($stable(slow_trim) && $stable(fast_trim))[*6])
        else $error("trim moved in stop");
    chk_filter_hold: assert property (hold[*4] |=>
        $stable(fll_filter_value)) else $error("filter drifted");
    cover property ($rose(stop_mode));
    cover property ($changed(fast_trim));
    cover property (wr && paddr == ADDR_CTRL1 ##1 hold[*4]);
endmodule : irc_trim_props

bind clkgen_status_control irc_trim_props #(.FW(FW), .TW(TW)) props_u (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .stop_mode, .fll_up, .fll_down, .slow_trim, .fast_trim,
    .fast_irc_divider, .internal_ref_select, .irc_enable, .clock_mode,
    .fll_filter_value, .irq);

//--- sync2.sv
`timescale 1ns/1ps
// two-stage synchroniser for levels arriving from outside pclk
module sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : sync2

//--- trim_sar.sv
`timescale 1ns/1ps
// successive approximation over the trim code, msb first
module trim_sar
    import clkgen_pkg::*;
#(
    parameter int WIDTH  = TRIM_WIDTH,
    parameter int SETTLE = TRIM_SETTLE_CYCLES
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // control
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic             too_fast,
    // results
    output logic      [WIDTH-1:0] code,
    output logic                  busy,
    output logic                  done
);
    if (WIDTH < 1 || WIDTH > 8 || SETTLE < 1) begin : g_bad
        $error("trim_sar: unsupported WIDTH or SETTLE");
    end

    trim_state_t state;
    logic [3:0]  idx;
    logic [15:0] cnt;
    wire  [WIDTH-1:0] cur_bit  = WIDTH'(1) << idx;
    wire  [WIDTH-1:0] next_bit = WIDTH'(1) << (idx - 4'd1);
    wire              last_tick = (cnt == 16'(SETTLE - 1));

    assign busy = (state != TRIM_IDLE);

    // abort wins over every step; a decided bit is never revisited
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= TRIM_IDLE;
            idx   <= '0;
            cnt   <= '0;
            code  <= '0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                state <= TRIM_IDLE;
            end else begin
                unique case (state)
                    TRIM_IDLE: begin
                        if (start) begin
                            idx   <= 4'(WIDTH - 1);
                            code  <= WIDTH'(1) << (WIDTH - 1);
                            cnt   <= '0;
                            state <= TRIM_SETTLE;
                        end
                    end
                    TRIM_SETTLE: begin
                        cnt <= cnt + 16'd1;
                        if (last_tick) begin
                            state <= TRIM_DECIDE;
                        end
                    end
                    TRIM_DECIDE: begin
                        cnt <= '0;
                        if (idx == 4'd0) begin
                            code  <= too_fast ? (code & ~cur_bit) : code;
                            done  <= 1'b1;
                            state <= TRIM_IDLE;
                        end else begin
                            code  <= (too_fast ? (code & ~cur_bit) : code)
                                     | next_bit;
                            idx   <= idx - 4'd1;
                            state <= TRIM_SETTLE;
                        end
                    end
                    default: state <= TRIM_IDLE;
                endcase
            end
        end
    end
endmodule : trim_sar
